/* File: hw/wgfc_counter.sv */
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/100ps
// Operation
// R1 - Pulse-width mode, both edges: starting while event is high raises the interrupt.
// R2 - Gate-running flag is meaningless in pulse-width mode.
// R3 - Pulse-width counts falling edges of event AND internal clock.
// R4 - Frequency mode counts event edges only while gate high, external clock selected.
// R5 - Software selects the external gate pin with gate source 00.
// R6 - Frequency mode interrupts on gate falling edge, or both edges.
// R7 - Read count while gate low, then clear; otherwise counting resumes.
// R8 - Status shows the current gate state in frequency mode.
// R9 - Wrap from maximum to zero sets the overflow flag.
// R10 - Overflow flag holds until the counter is cleared.
// R11 - Route bit 0 drives partner output to pin; 1 suppresses it.
// R12 - Gate high period is sixteen minus high setting, times the tick.
// R13 - Gate low period is sixteen minus low setting, times the tick.
// R14 - Internal gate alternates high and low periods; cycle is their sum.
// R15 - Internal gate follows the prescaler, may start one tick late.
// R16 - Change gate settings while stopped or low; low takes effect next low.
// R17 - Edge mode 1: gate falling edge adds one regardless of event.
// R18 - Edge mode 0: count falls of event AND gate.
// R19 - Software stops the timer with interrupts masked and the latch cleared.
// R20 - Gate-running flag is 1 in high period, 0 when low or disabled.
// R21 - Interrupt edge select 0 falling only, 1 both edges.
// R22 - Tick select 11 is reserved and makes no gate.
// R23 - Counter is 18 bits; high and low settings are 4 bits each.
module wgfc_counter
  import wgfc_pkg::*;
#(
  parameter int COUNT_W = 18,
  parameter int FC_TICK_LOG2 = 12
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement pins.
  input wire wgfc_pins_t pins,
  input wire logic partner_pulse_output,
  // Results.
  output logic measure_counter_irq,
  output logic shared_port_pin,
  output logic shared_port_pin_oe_n
);

  logic [1:0] start_stop_field;
  logic [2:0] counter_clock_select;
  wgfc_mode_t mode;
  logic edge_mode_bit;
  logic gate_irq_edge_select;
  logic [1:0] gate_source_select;
  logic [1:0] gate_tick_select;
  logic partner_output_route_bit;
  logic prescaler_source_bit;
  logic [3:0] gate_high_setting;
  logic [3:0] gate_low_setting;
  logic [COUNT_W-1:0] count_value;
  logic counter_overflow_flag;
  logic gate_running_flag;

  wgfc_pins_t sync1;
  wgfc_pins_t sync2;
  wgfc_pins_t prev;
  logic [15:0] divider;
  logic gate_int;
  logic gate_low;
  logic gate;
  logic gate_d;
  logic pw_and_d;
  logic pw_and;
  logic int_clk;
  logic running;
  logic freq_mode;
  logic pw_mode;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic clr;
  logic start_wr;
  logic inc;
  logic ev_rise;
  logic ev_fall;
  logic gate_rise;
  logic gate_fall;
  logic next_irq;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Pins pass two flip-flops; prev looks only at the second stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. One wait state: pready rises in the second access cycle.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == WGFC_OFS_CTRL1) || (a == WGFC_OFS_CTRL2) || (a == WGFC_OFS_STATUS) ||
           (a == WGFC_OFS_COUNT) || (a == WGFC_OFS_PERIOD);
  endfunction

  assign addr_ok = is_mapped(paddr);
  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign rd_en = psel && penable && !pready;
  assign clr = wr_en && (paddr == WGFC_OFS_CTRL1) && pwdata[WGFC_C1_CLEAR]; // see R7
  assign start_wr = wr_en && (paddr == WGFC_OFS_CTRL1) &&
                    (pwdata[WGFC_C1_START +: 2] == WGFC_START_RUN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= rd_en;
      pslverr <= rd_en && !is_mapped(paddr);
      if (rd_en && !pwrite)
        prdata <= rd_mux;
    end
  end

  always_comb
  begin
    rd_mux = '0;
    case (paddr)
      WGFC_OFS_CTRL1:
      begin
        rd_mux[WGFC_C1_START +: 2] = start_stop_field;
        rd_mux[WGFC_C1_CLKSEL +: 3] = counter_clock_select;
        rd_mux[WGFC_C1_MODE +: 2] = mode;
      end
      WGFC_OFS_CTRL2:
      begin
        rd_mux[WGFC_C2_EDGE_MODE] = edge_mode_bit;
        rd_mux[WGFC_C2_IRQ_EDGE] = gate_irq_edge_select;
        rd_mux[WGFC_C2_GATE_SRC +: 2] = gate_source_select;
        rd_mux[WGFC_C2_TICK_SEL +: 2] = gate_tick_select;
        rd_mux[WGFC_C2_ROUTE] = partner_output_route_bit;
        rd_mux[WGFC_C2_PRESC_SRC] = prescaler_source_bit;
      end
      WGFC_OFS_STATUS:
      begin
        rd_mux[WGFC_SR_RUNNING] = gate_running_flag; // see R8
        rd_mux[WGFC_SR_OVERFLOW] = counter_overflow_flag;
      end
      WGFC_OFS_COUNT:
        rd_mux[COUNT_W-1:0] = count_value;
      WGFC_OFS_PERIOD:
      begin
        rd_mux[WGFC_PR_HIGH +: 4] = gate_high_setting;
        rd_mux[WGFC_PR_LOW +: 4] = gate_low_setting;
      end
      default:
        rd_mux = '0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers. Software is trusted to change modes only while stopped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_stop_field <= WGFC_RST_CTRL[1:0];
      counter_clock_select <= WGFC_RST_CTRL[4:2];
      mode <= WGFC_MODE_PULSE_WIDTH;
      edge_mode_bit <= WGFC_RST_CTRL[0];
      gate_irq_edge_select <= WGFC_RST_CTRL[0];
      gate_source_select <= WGFC_RST_CTRL[1:0];
      gate_tick_select <= WGFC_RST_CTRL[1:0];
      partner_output_route_bit <= WGFC_RST_CTRL[0];
      prescaler_source_bit <= WGFC_RST_CTRL[0];
      gate_high_setting <= WGFC_RST_PERIOD[3:0];
      gate_low_setting <= WGFC_RST_PERIOD[7:4];
    end
    else if (wr_en)
    begin
      case (paddr)
        WGFC_OFS_CTRL1:
        begin
          start_stop_field <= pwdata[WGFC_C1_START +: 2];
          counter_clock_select <= pwdata[WGFC_C1_CLKSEL +: 3];
          mode <= pwdata[WGFC_C1_MODE] ? WGFC_MODE_FREQUENCY : WGFC_MODE_PULSE_WIDTH;
        end
        WGFC_OFS_CTRL2:
        begin
          edge_mode_bit <= pwdata[WGFC_C2_EDGE_MODE];
          gate_irq_edge_select <= pwdata[WGFC_C2_IRQ_EDGE];
          gate_source_select <= pwdata[WGFC_C2_GATE_SRC +: 2]; // see R5
          gate_tick_select <= pwdata[WGFC_C2_TICK_SEL +: 2];
          partner_output_route_bit <= pwdata[WGFC_C2_ROUTE];
          prescaler_source_bit <= pwdata[WGFC_C2_PRESC_SRC];
        end
        WGFC_OFS_PERIOD:
        begin
          gate_high_setting <= pwdata[WGFC_PR_HIGH +: 4]; // see R16 R23
          gate_low_setting <= pwdata[WGFC_PR_LOW +: 4];
        end
        default:
          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gate selection and internal clock for pulse-width measurement.
  assign running = (start_stop_field == WGFC_START_RUN);
  assign freq_mode = (mode == WGFC_MODE_FREQUENCY);
  assign pw_mode = (mode == WGFC_MODE_PULSE_WIDTH);
  assign int_clk = divider[{counter_clock_select, 1'b1}];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      divider <= '0;
    else
      divider <= divider + 1'b1;
  end

  wgfc_gate_gen #(
    .FC_TICK_LOG2(FC_TICK_LOG2)
  ) u_gate_gen (
    .pclk(pclk),
    .presetn(presetn),
    .run(running && freq_mode && (gate_source_select == WGFC_GATE_INTERNAL)),
    .use_low_freq(prescaler_source_bit),
    .low_freq_edge(sync2.low_freq_clk && !prev.low_freq_clk),
    .tick_sel(gate_tick_select),
    .high_setting(gate_high_setting),
    .low_setting(gate_low_setting),
    .gate(gate_int),
    .low_period(gate_low)
  );

  always_comb
  begin
    case (gate_source_select)
      WGFC_GATE_PIN: gate = sync2.gate_pin;
      WGFC_GATE_PARTNER: gate = partner_pulse_output;
      WGFC_GATE_INTERNAL: gate = gate_int;
      default: gate = 1'b0;
    endcase
  end

  assign pw_and = sync2.event_in && int_clk;
  assign ev_rise = sync2.event_in && !prev.event_in;
  assign ev_fall = !sync2.event_in && prev.event_in;
  assign gate_rise = gate && !gate_d;
  assign gate_fall = !gate && gate_d;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_d <= 1'b0;
      pw_and_d <= 1'b0;
    end
    else
    begin
      gate_d <= gate;
      pw_and_d <= pw_and;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count condition per mode.
  always_comb
  begin
    inc = 1'b0;
    if (running && pw_mode)
      inc = pw_and_d && !pw_and; // see R3
    else if (running && freq_mode && (counter_clock_select == WGFC_CLK_EXTERNAL)) // see R4
    begin
      if (edge_mode_bit)
        inc = gate_d && (gate ? (ev_rise || ev_fall) : 1'b1); // see R17
      else
        inc = (prev.event_in && gate_d) && !(sync2.event_in && gate); // see R18
    end
  end

  // A clear that meets a count leaves the count at one, so no edge is lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value <= '0;
    else if (clr)
      count_value <= COUNT_W'(inc); // see R7
    else if (inc)
      count_value <= count_value + 1'b1; // see R23
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter_overflow_flag <= 1'b0;
    else
      counter_overflow_flag <= (inc && !clr && (count_value == WGFC_COUNT_MAX[COUNT_W-1:0])) || // see R9
                               (counter_overflow_flag && !clr); // see R10
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_running_flag <= 1'b0;
    else
      gate_running_flag <= running && freq_mode && gate && !(gate_low && gate_source_select ==
                           WGFC_GATE_INTERNAL); // see R2 R20
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse.
  always_comb
  begin
    next_irq = 1'b0;
    if (pw_mode && start_wr && gate_irq_edge_select && sync2.event_in && !running)
      next_irq = 1'b1; // see R1
    else if (running && pw_mode)
      next_irq = ev_fall || (gate_irq_edge_select && ev_rise);
    else if (running && freq_mode)
      next_irq = gate_fall || (gate_irq_edge_select && gate_rise); // see R6 R21
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      measure_counter_irq <= 1'b0;
    else
      measure_counter_irq <= next_irq;
  end

  // The route bit only gates the pin; the partner timer keeps running.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shared_port_pin <= 1'b0;
      shared_port_pin_oe_n <= 1'b1;
    end
    else
    begin
      shared_port_pin <= partner_pulse_output && !partner_output_route_bit; // see R11
      shared_port_pin_oe_n <= partner_output_route_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start_high;
    pw_mode && gate_irq_edge_select && !running && start_wr && sync2.event_in;
  endsequence

  property p_start_irq;
    @(posedge pclk) disable iff (!presetn)
    s_start_high |=> measure_counter_irq;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("no irq at start with event high"); // see R1

  property p_pw_flag;
    @(posedge pclk) disable iff (!presetn)
    pw_mode ##1 pw_mode |-> !gate_running_flag;
  endproperty
  a_pw_flag: assert property (p_pw_flag) else $error("running flag set in pulse width mode"); // see R2

  property p_freq_gate_fall_irq;
    @(posedge pclk) disable iff (!presetn)
    (running && freq_mode && gate_fall) |=> measure_counter_irq;
  endproperty
  a_freq_gate_fall_irq: assert property (p_freq_gate_fall_irq) else $error("gate fall gave no irq"); // see R6

  property p_rise_needs_both;
    @(posedge pclk) disable iff (!presetn)
    (running && freq_mode && gate_rise && !gate_irq_edge_select) |=> !measure_counter_irq;
  endproperty
  a_rise_needs_both: assert property (p_rise_needs_both) else $error("irq on rise with falling only"); // see R21

  property p_no_ext_no_count;
    @(posedge pclk) disable iff (!presetn)
    (freq_mode && counter_clock_select != WGFC_CLK_EXTERNAL && !clr) |=> $stable(count_value);
  endproperty
  a_no_ext_no_count: assert property (p_no_ext_no_count) else $error("counted without external clock"); // see R4

  property p_overflow_set;
    @(posedge pclk) disable iff (!presetn)
    (inc && !clr && count_value == WGFC_COUNT_MAX[COUNT_W-1:0]) |=> counter_overflow_flag && count_value == '0;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("wrap did not set overflow"); // see R9

  property p_overflow_hold;
    @(posedge pclk) disable iff (!presetn)
    (counter_overflow_flag && !clr) [*2] |=> counter_overflow_flag;
  endproperty
  a_overflow_hold: assert property (p_overflow_hold) else $error("overflow dropped without clear"); // see R10

  property p_clear;
    @(posedge pclk) disable iff (!presetn)
    clr |=> count_value <= COUNT_W'(1);
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a count"); // see R7

  property p_route;
    @(posedge pclk) disable iff (!presetn)
    !partner_output_route_bit |=> (shared_port_pin == $past(partner_pulse_output)) && !shared_port_pin_oe_n;
  endproperty
  a_route: assert property (p_route) else $error("partner output not routed"); // see R11

  property p_const_event_one;
    @(posedge pclk) disable iff (!presetn)
    (running && freq_mode && edge_mode_bit && gate_fall &&
     counter_clock_select == WGFC_CLK_EXTERNAL && !clr) |=> count_value == $past(count_value) + 1'b1;
  endproperty
  a_const_event_one: assert property (p_const_event_one) else $error("gate fall added no count"); // see R17

endmodule

/* File: hw/wgfc_pkg.sv */
package wgfc_pkg;

  // Register byte offsets.
  localparam logic [7:0] WGFC_OFS_CTRL1 = 8'h00;
  localparam logic [7:0] WGFC_OFS_CTRL2 = 8'h04;
  localparam logic [7:0] WGFC_OFS_STATUS = 8'h08;
  localparam logic [7:0] WGFC_OFS_COUNT = 8'h0c;
  localparam logic [7:0] WGFC_OFS_PERIOD = 8'h10;

  // Field positions of measure_control_one.
  localparam int WGFC_C1_START = 0;
  localparam int WGFC_C1_CLEAR = 2;
  localparam int WGFC_C1_CLKSEL = 3;
  localparam int WGFC_C1_MODE = 6;

  // Field positions of measure_control_two.
  localparam int WGFC_C2_EDGE_MODE = 0;
  localparam int WGFC_C2_IRQ_EDGE = 1;
  localparam int WGFC_C2_GATE_SRC = 2;
  localparam int WGFC_C2_TICK_SEL = 4;
  localparam int WGFC_C2_ROUTE = 6;
  localparam int WGFC_C2_PRESC_SRC = 7;

  // Field positions of measure_status_register and gate_period_register.
  localparam int WGFC_SR_RUNNING = 7;
  localparam int WGFC_SR_OVERFLOW = 6;
  localparam int WGFC_PR_HIGH = 0;
  localparam int WGFC_PR_LOW = 4;

  // Field encodings and reset values.
  localparam logic [1:0] WGFC_START_STOP = 2'h0;
  localparam logic [1:0] WGFC_START_RUN = 2'h2;
  localparam logic [2:0] WGFC_CLK_EXTERNAL = 3'h7;
  localparam logic [1:0] WGFC_GATE_PIN = 2'h0;
  localparam logic [1:0] WGFC_GATE_PARTNER = 2'h1;
  localparam logic [1:0] WGFC_GATE_INTERNAL = 2'h2;
  localparam logic [1:0] WGFC_TICK_RESERVED = 2'h3;
  localparam logic [7:0] WGFC_RST_CTRL = 8'h00;
  localparam logic [7:0] WGFC_RST_PERIOD = 8'h00;
  localparam logic [17:0] WGFC_COUNT_MAX = 18'h3ffff;
  localparam logic [4:0] WGFC_PERIOD_BASE = 5'h10;
  localparam int WGFC_FS_TICK_LOG2 = 4;

  typedef enum logic [1:0] {
    WGFC_MODE_PULSE_WIDTH = 2'h2,
    WGFC_MODE_FREQUENCY = 2'h3
  } wgfc_mode_t;

  typedef enum logic [2:0] {
    WGFC_GS_IDLE = 3'b001,
    WGFC_GS_HIGH = 3'b010,
    WGFC_GS_LOW = 3'b100
  } wgfc_gate_state_t;

  // Asynchronous pin inputs, synchronised as one bundle.
  typedef struct packed {
    logic event_in;
    logic gate_pin;
    logic low_freq_clk;
  } wgfc_pins_t;

endpackage

/* File: hw/wgfc_gate_gen.sv */
`timescale 1ns/100ps
module wgfc_gate_gen
  import wgfc_pkg::*;
#(
  parameter int FC_TICK_LOG2 = 12,
  parameter int PRESC_W = 16
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic run,
  input wire logic use_low_freq,
  input wire logic low_freq_edge,
  input wire logic [1:0] tick_sel,
  input wire logic [3:0] high_setting,
  input wire logic [3:0] low_setting,
  // Result.
  output logic gate,
  output logic low_period
);

  logic [PRESC_W-1:0] presc;
  logic [PRESC_W-1:0] mask;
  logic src;
  logic tick;
  logic [4:0] remain;
  wgfc_gate_state_t state;

  ////////////////////////////////////////////////////////////////////////////
  // The prescaler runs free, so the first period waits for its next tick.
  always_comb
  begin
    src = use_low_freq ? low_freq_edge : 1'b1;
    mask = use_low_freq ? PRESC_W'((1 << (WGFC_FS_TICK_LOG2 + int'(tick_sel))) - 1)
                        : PRESC_W'((1 << (FC_TICK_LOG2 + int'(tick_sel))) - 1);
    tick = src && ((presc & mask) == mask) && (tick_sel != WGFC_TICK_RESERVED); // see R12 R22
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      presc <= '0;
    else if (src)
      presc <= presc + 1'b1; // see R15
  end

  ////////////////////////////////////////////////////////////////////////////
  // Each period is loaded as it starts, so a new low setting waits for the next low period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= WGFC_GS_IDLE;
      remain <= '0;
    end
    else if (!run)
    begin
      state <= WGFC_GS_IDLE;
      remain <= '0;
    end
    else if (tick)
    begin
      case (state)
        WGFC_GS_IDLE:
        begin
          state <= WGFC_GS_HIGH;
          remain <= WGFC_PERIOD_BASE - {1'b0, high_setting}; // see R12
        end
        WGFC_GS_HIGH:
        begin
          if (remain == 5'h01)
          begin
            state <= WGFC_GS_LOW; // see R14
            remain <= WGFC_PERIOD_BASE - {1'b0, low_setting}; // see R13 R16
          end
          else
            remain <= remain - 1'b1;
        end
        WGFC_GS_LOW:
        begin
          if (remain == 5'h01)
          begin
            state <= WGFC_GS_HIGH; // see R14
            remain <= WGFC_PERIOD_BASE - {1'b0, high_setting};
          end
          else
            remain <= remain - 1'b1;
        end
        default:
        begin
          state <= WGFC_GS_IDLE;
          remain <= '0;
        end
      endcase
    end
  end

  assign gate = (state == WGFC_GS_HIGH);
  assign low_period = (state != WGFC_GS_HIGH);

  property p_gate_on_tick;
    @(posedge pclk) disable iff (!presetn)
    $rose(gate) |-> $past(tick);
  endproperty
  a_gate_on_tick: assert property (p_gate_on_tick) else $error("gate rose without a tick"); // see R15

  property p_reserved_no_tick;
    @(posedge pclk) disable iff (!presetn)
    (tick_sel == WGFC_TICK_RESERVED) |-> !tick;
  endproperty
  a_reserved_no_tick: assert property (p_reserved_no_tick) else $error("reserved tick select ticked"); // see R22

endmodule

/* File: testbench/wgfc_src.sv */
`timescale 1ns/100ps
module wgfc_src
  import wgfc_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Commands from the bench.
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic ev_hold,
  input wire logic gate_lvl,
  input wire logic part_lvl,
  // Pins.
  output wgfc_pins_t pins,
  output logic busy,
  output logic partner_pulse_output
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph = 3'h0;
  logic [3:0] fs_div = 4'h0;

  // Pulses are 4 cycles high and 4 low, so the two-flop synchroniser never misses an edge.
  always_ff @(posedge pclk)
  begin
    fs_div <= fs_div + 4'h1;
    if (go && left == 8'h00)
      left <= n_pulses;
    else if (left != 8'h00 && ph == 3'h7)
      left <= left - 8'h01;
    ph <= (left != 8'h00) ? ph + 3'h1 : 3'h0;
  end

  assign busy = go || (left != 8'h00);
  assign pins.event_in = (left != 8'h00) ? ~ph[2] : ev_hold;
  assign pins.gate_pin = gate_lvl;
  assign pins.low_freq_clk = fs_div[3];
  assign partner_pulse_output = part_lvl;
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  import wgfc_pkg::*;
  localparam int CW = 6;
  localparam int FTL = 2;
  localparam logic [31:0] FRUN = 32'h7a;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wgfc_pins_t pins;
  logic ppo;
  logic irq;
  logic spp;
  logic spp_oe_n;
  logic busy;
  logic go = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic ev_hold = 1'b0;
  logic gate_lvl = 1'b0;
  logic part_lvl = 1'b0;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'he20d03d7;
  int cyc = 0;
  int irq_n = 0;
  int irq_t[$];

  wgfc_counter #(.COUNT_W(CW), .FC_TICK_LOG2(FTL)) u_wgfc_counter (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .partner_pulse_output(ppo), .measure_counter_irq(irq),
    .shared_port_pin(spp), .shared_port_pin_oe_n(spp_oe_n));
  wgfc_src u_wgfc_src (.pclk(pclk), .go(go), .n_pulses(n_pulses), .ev_hold(ev_hold), .gate_lvl(gate_lvl),
    .part_lvl(part_lvl), .pins(pins), .busy(busy), .partner_pulse_output(ppo));

  initial
  begin
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
    begin
      irq_n <= irq_n + 1;
      irq_t.push_back(cyc);
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hang();
    mismatches++;
    results();
  endtask

  // The request is held until pready is sampled high; an extra idle edge keeps calls from colliding.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string s);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(s, q, x);
  endtask

  task automatic pulses(input int n, input logic hold);
    int k;
    n_pulses <= 8'(n);
    ev_hold <= hold;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    for (k = 0; busy !== 1'b0; k++)
    begin
      if (k > 3000)
        hang();
      @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
  endtask

  task automatic gate(input logic lvl);
    gate_lvl <= lvl;
    repeat (6) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    logic e;
    int n, m, i, k, ta, tl, tick;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(WGFC_OFS_CTRL2, 32'h0, "ctrl2 reset");
    rdc(WGFC_OFS_STATUS, 32'h0, "status reset");
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wr(WGFC_OFS_CTRL2, 32'h0);
    wr(WGFC_OFS_CTRL1, FRUN);
    n = 1 + ($unsigned($random(seed)) % 20);
    m = 1 + ($unsigned($random(seed)) % 20);
    k = irq_n;
    pulses(3, 1'b0);
    gate(1'b1);
    rdc(WGFC_OFS_STATUS, 32'h80, "running high");
    pulses(n, 1'b0);
    gate(1'b0);
    rdc(WGFC_OFS_STATUS, 32'h0, "running low");
    rdc(WGFC_OFS_COUNT, 32'(n), "count");
    chk("irq fall only", 32'(irq_n - k), 32'h1);
    gate(1'b1);
    pulses(m, 1'b0);
    gate(1'b0);
    rdc(WGFC_OFS_COUNT, 32'(n + m), "resumed");
    wr(WGFC_OFS_CTRL1, FRUN | 32'h4);
    rdc(WGFC_OFS_COUNT, 32'h0, "cleared");
    for (i = 0; i < 2; i++)
    begin
      wr(WGFC_OFS_CTRL1, FRUN | 32'h4);
      wr(WGFC_OFS_CTRL2, 32'(i) | 32'h2);
      pulses(0, 1'b1);
      k = irq_n;
      gate(1'b1);
      gate(1'b0);
      rdc(WGFC_OFS_COUNT, 32'h1, "constant event");
      chk("irq both", 32'(irq_n - k), 32'h2);
    end
    pulses(0, 1'b0);
    wr(WGFC_OFS_CTRL2, 32'h0);
    wr(WGFC_OFS_CTRL1, FRUN | 32'h4);
    gate(1'b1);
    pulses(1 << CW, 1'b0);
    gate(1'b0);
    rdc(WGFC_OFS_COUNT, 32'h0, "wrapped");
    rdc(WGFC_OFS_STATUS, 32'h40, "overflow set");
    gate(1'b1);
    pulses(3, 1'b0);
    gate(1'b0);
    rdc(WGFC_OFS_STATUS, 32'h40, "overflow held");
    wr(WGFC_OFS_CTRL1, FRUN | 32'h4);
    rdc(WGFC_OFS_STATUS, 32'h0, "overflow cleared");
    for (i = 0; i < 2; i++)
    begin
      wr(WGFC_OFS_CTRL2, 32'(i) << WGFC_C2_ROUTE);
      part_lvl <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("port pin", {31'h0, spp}, 32'(1 - i));
      chk("port oe_n", {31'h0, spp_oe_n}, 32'(i));
      part_lvl <= 1'b0;
    end
    // Tick select 3 is the reserved code and must produce no gate edges at all.
    for (i = 0; i < 4; i++)
    begin
      ta = 8 + ($unsigned($random(seed)) % 8);
      tl = 8 + ($unsigned($random(seed)) % 8);
      tick = 1 << (FTL + i);
      wr(WGFC_OFS_CTRL1, FRUN & ~32'h2);
      wr(WGFC_OFS_PERIOD, 32'(tl << WGFC_PR_LOW | ta));
      wr(WGFC_OFS_CTRL2, 32'h0a | 32'(i) << WGFC_C2_TICK_SEL);
      irq_t.delete();
      wr(WGFC_OFS_CTRL1, FRUN);
      for (k = 0; irq_t.size() < 4 && k < 800; k++)
        @(posedge pclk);
      if (i == 3)
        chk("reserved tick", 32'(irq_t.size()), 32'h0);
      else if (irq_t.size() < 4)
        hang();
      else
      begin
        chk("high period", 32'(irq_t[3] - irq_t[2]), 32'((16 - ta) * tick));
        chk("low period", 32'(irq_t[2] - irq_t[1]), 32'((16 - tl) * tick));
      end
    end
    rdc(WGFC_OFS_STATUS, 32'h0, "no gate");
    wr(WGFC_OFS_CTRL1, 32'h0);
    wr(WGFC_OFS_CTRL2, 32'h2);
    pulses(0, 1'b1);
    k = irq_n;
    wr(WGFC_OFS_CTRL1, 32'h2);
    repeat (4) @(posedge pclk);
    chk("start irq", 32'(irq_n - k), 32'h1);
    rdc(WGFC_OFS_STATUS, 32'h0, "pulse width flag");
    results();
  end
endmodule
